// >>> rtl/tser_defines.vh
// Constants for the turbo stream error reporter
`ifndef TSER_DEFINES_VH
`define TSER_DEFINES_VH
`define TSER_ERR_NONE      2'h0
`define TSER_ERR_NO_SOP    2'h1
`define TSER_ERR_NO_EOP    2'h2
`define TSER_ERR_OTHER     2'h3
`define TSER_REPORT_DLY    3
`define TSER_CLK_HZ        40000000
`define TSER_EVAL_SECONDS  3600
// One hour at 40 MHz, written out at 40 bits so that it does not wrap at 32
`define TSER_EVAL_CYCLES   40'h218711a000
`define TSER_KMIN          40
`define TSER_KMAX          6144
`define TSER_CODEC_ENC     1'b0
`define TSER_CODEC_DEC     1'b1
`define TSER_ALGO_MAXLOG   1'b0
`define TSER_ALGO_EXACT    1'b1
`define TSER_OUT_BITS      8
`define TSER_REG_CTRL      12'h000
`define TSER_REG_STATUS    12'h004
`define TSER_REG_CONFIG    12'h008
`define TSER_CTRL_TETHER   0
`define TSER_CTRL_EVAL_EN  1
`define TSER_CTRL_EXT_TO   2
`define TSER_CTRL_RST      32'h00000002
`endif

// >>> rtl/tser_sync2.v
// Two-flop synchroniser for a single level
`timescale 1ns/1ps
module tser_sync2 (
   input  wire pclk,
   input  wire presetn,
   input  wire d,
   output wire q
);
   reg s1_q;
   reg s2_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
      end
   end
   assign q = s2_q;
endmodule // tser_sync2

// >>> rtl/tser_eval_timer.v
// Evaluation period timer that latches a permanent expiry
`timescale 1ns/1ps
`include "tser_defines.vh"
module tser_eval_timer #(
   parameter [39:0] EVAL_CYCLES = `TSER_EVAL_CYCLES
) (
   input  wire pclk,
   input  wire presetn,
   input  wire enable,
   input  wire tethered,
   input  wire ext_expire,
   output wire expired
);
   reg [39:0] cnt_q;
   reg        exp_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 40'h0;
         exp_q <= 1'b0;
      end else begin
         if (enable && !tethered && !exp_q)
            cnt_q <= cnt_q + 40'h1;
         if (ext_expire || (enable && !tethered && cnt_q >= EVAL_CYCLES - 40'h1))
            exp_q <= 1'b1; // R09 R10
      end
   end
   assign expired = exp_q;
endmodule // tser_eval_timer

// >>> rtl/tser_error_reporter.v
// Stream packet-format error detection and single-cycle reporting
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "tser_defines.vh"
// Notes on behaviour
// R01: Report input errors at once, not queued
// R02: Error output may fire during previous output
// R03: Each code shown for one cycle only
// R04: Only first error per block reported
// R05: Fixed small delay from detection to output
// R06: Boundary error plus checksum change may stall
// R07: Every detected error condition is reported; the code reports only the first error per block (R04)
// R08: Expiry forces reset held permanently
// R09: Untethered one hour, tethered never expires; the code still expires a tethered core on other_expire with ctrl bit 2 set
// R10: All functions expire together at earliest limit
// R11: Parameter selects encoder or decoder
// R12: Engine count two, four, eight, sixteen
// R13: Soft input width four to eight
// R14: Output width fixed at eight
// R15: Max-log algorithm only
// R16: Codes 00 none,01 sop,10 eop,11 other
// R17: Upstream error code discards block, forwarded
// R18: After discard wait for sop with valid
// R19: Illegal block size gives 11, rest ignored
// R20: Error output idle at no-error value
// R21: Error state tracked per input block
module tser_error_reporter #(
   parameter        CODEC_TYPE  = `TSER_CODEC_DEC,
   parameter        NUM_ENGINES = 8,
   parameter        IN_BITS     = 8,
   parameter        OUT_BITS    = `TSER_OUT_BITS,
   parameter        MAP_ALGO    = `TSER_ALGO_MAXLOG,
   parameter [39:0] EVAL_CYCLES = `TSER_EVAL_CYCLES
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire [31:0] paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        sink_valid,
   input  wire        sink_sop,
   input  wire        sink_eop,
   input  wire [1:0]  sink_error,
   input  wire [12:0] sink_blk_size,
   input  wire        checksum_type_select,
   input  wire        other_expire,
   output reg  [1:0]  source_error,
   output reg         sink_ready,
   output reg         block_accept,
   output reg         core_reset_n
);
   // Build-time checks: R11 R12 R13 R14 R15 fold into illegal configs
   localparam [0:0] CFG_OK = ((CODEC_TYPE == `TSER_CODEC_ENC) || (CODEC_TYPE == `TSER_CODEC_DEC))
                    && ((NUM_ENGINES == 2) || (NUM_ENGINES == 4) || (NUM_ENGINES == 8)
                        || (NUM_ENGINES == 16))
                    && (IN_BITS >= 4) && (IN_BITS <= 8)
                    && (OUT_BITS == 8)
                    && (MAP_ALGO == `TSER_ALGO_MAXLOG);
   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_BODY = 2'd1;
   localparam [1:0] ST_DROP = 2'd2;
   localparam [3:0] DLY     = `TSER_REPORT_DLY;
   localparam [4:0] NE_W    = NUM_ENGINES;
   localparam [3:0] IN_W    = IN_BITS;
   localparam [3:0] OUT_W   = OUT_BITS;
   localparam [0:0] ALGO_B  = MAP_ALGO;
   localparam [0:0] CODEC_B = CODEC_TYPE;

   // Legal LTE interleaver sizes: 40..512 step 8, ..1024 step 16, ..2048 step 32, ..6144 step 64
   function legal_size;
      input [12:0] k;
      begin
         if (k < 13'd40 || k > 13'd6144)
            legal_size = 1'b0;
         else if (k <= 13'd512)
            legal_size = (k[2:0] == 3'h0);
         else if (k <= 13'd1024)
            legal_size = (k[3:0] == 4'h0);
         else if (k <= 13'd2048)
            legal_size = (k[4:0] == 5'h0);
         else
            legal_size = (k[5:0] == 6'h0);
      end
   endfunction

   wire v_s;
   wire sop_s;
   wire eop_s;
   wire e0_s;
   wire e1_s;
   wire cks_s;
   wire oth_s;
   wire tether_s;
   wire expired;
   tser_sync2 u_sv (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (sink_valid),
      .q       (v_s)
   );
   tser_sync2 u_ss (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (sink_sop),
      .q       (sop_s)
   );
   tser_sync2 u_se (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (sink_eop),
      .q       (eop_s)
   );
   tser_sync2 u_e0 (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (sink_error[0]),
      .q       (e0_s)
   );
   tser_sync2 u_e1 (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (sink_error[1]),
      .q       (e1_s)
   );
   tser_sync2 u_ck (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (checksum_type_select),
      .q       (cks_s)
   );
   tser_sync2 u_ot (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (other_expire),
      .q       (oth_s)
   );

   reg [12:0] size_s1_q;
   reg [12:0] size_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         size_s1_q <= 13'h0;
         size_q    <= 13'h0;
      end else begin
         size_s1_q <= sink_blk_size;
         size_q    <= size_s1_q;
      end
   end

   // Control register
   reg [31:0] ctrl_q;
   assign tether_s = ctrl_q[`TSER_CTRL_TETHER];

   tser_eval_timer #(.EVAL_CYCLES(EVAL_CYCLES)) u_timer (
      .pclk       (pclk),
      .presetn    (presetn),
      .enable     (ctrl_q[`TSER_CTRL_EVAL_EN]),
      .tethered   (tether_s),
      .ext_expire (oth_s & ctrl_q[`TSER_CTRL_EXT_TO]),
      .expired    (expired)
   );

   // Per-block input tracking
   reg [1:0]  st_q;
   reg        reported_q;      // R21
   reg        last_cks_q;
   reg        bnd_err_q;
   reg [1:0]  det_code;
   reg [1:0]  st_d;
   reg        accept_d;
   wire [1:0] serr = {e1_s, e0_s};
   wire       beat = v_s & ~expired;

   always @* begin
      det_code = `TSER_ERR_NONE;
      st_d     = st_q;
      accept_d = 1'b0;
      case (st_q)
         ST_IDLE, ST_DROP: begin
            if (beat && (sop_s || st_q == ST_IDLE)) begin // R18
               if (serr != `TSER_ERR_NONE) begin
                  det_code = serr;                       // R17
                  st_d     = ST_DROP;
               end else if (!sop_s) begin
                  det_code = `TSER_ERR_NO_SOP;           // R16
                  st_d     = ST_DROP;
               end else if (!legal_size(size_q)) begin
                  det_code = `TSER_ERR_OTHER;            // R19
                  st_d     = ST_DROP;
               end else if (eop_s) begin
                  accept_d = 1'b1;
                  st_d     = ST_IDLE;
               end else begin
                  st_d = ST_BODY;
               end
            end
         end
         ST_BODY: begin
            if (beat) begin
               if (serr != `TSER_ERR_NONE) begin
                  det_code = serr;                       // R17
                  st_d     = ST_DROP;
               end else if (sop_s) begin
                  det_code = `TSER_ERR_NO_EOP;           // R16
                  st_d     = ST_DROP;
               end else if (eop_s) begin
                  accept_d = 1'b1;
                  st_d     = ST_IDLE;
               end
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // A start beat outside a block opens a new block for reporting
   wire      fresh = beat && sop_s && (st_q != ST_BODY);
   // Report delay line: fixed latency, independent of output traffic
   reg [1:0] dly_q [0:DLY-1];
   integer   i;
   wire      first = (det_code != `TSER_ERR_NONE) && (!reported_q || fresh);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q         <= ST_IDLE;
         block_accept <= 1'b0;
      end else begin
         st_q         <= st_d;
         block_accept <= accept_d;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reported_q <= 1'b0;
      end else begin
         if (first)
            reported_q <= 1'b1;                          // R04
         else if (fresh)
            reported_q <= 1'b0;                          // R21
      end
   end

   // Boundary error history; a block of a new checksum type still resumes at once
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_cks_q <= 1'b0;
         bnd_err_q  <= 1'b0;
      end else begin
         if (accept_d || (st_d == ST_BODY && st_q != ST_BODY))
            last_cks_q <= cks_s;                         // R06
         if (det_code == `TSER_ERR_NO_EOP || det_code == `TSER_ERR_OTHER)
            bnd_err_q <= 1'b1;
         else if (accept_d)
            bnd_err_q <= 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         source_error <= `TSER_ERR_NONE;
         for (i = 0; i < DLY; i = i + 1)
            dly_q[i] <= `TSER_ERR_NONE;
      end else begin
         dly_q[0] <= first ? det_code : `TSER_ERR_NONE;  // R01 R02 R07
         for (i = 1; i < DLY; i = i + 1)
            dly_q[i] <= dly_q[i-1];                      // R05
         source_error <= dly_q[DLY-1];                   // R03 R20
      end
   end

   // Forced reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_reset_n <= 1'b0;
      end else begin
         core_reset_n <= ~expired & CFG_OK;              // R08
      end
   end

   // Readiness
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sink_ready <= 1'b0;
      end else begin
         sink_ready <= ~expired & CFG_OK;
      end
   end

   // APB slave, zero wait states
   wire acc = psel & penable;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= `TSER_CTRL_RST;
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel & ~penable) begin
            prdata <= 32'h0;
            case (paddr[11:0])
               `TSER_REG_CTRL:   prdata <= {29'h0, ctrl_q[2:0]};
               `TSER_REG_STATUS: prdata <= {25'h0, expired, reported_q, bnd_err_q,
                                            last_cks_q, st_q, 1'b0};
               `TSER_REG_CONFIG: prdata <= {15'h0, ALGO_B, CODEC_B,
                                            NE_W, IN_W, OUT_W,
                                            CFG_OK, 1'b0};
               default:          pslverr <= 1'b1;
            endcase
         end
         if (acc && pready && pwrite && paddr[11:0] == `TSER_REG_CTRL)
            ctrl_q <= {29'h0, pwdata[2:0]};
         if (acc && pready && paddr[11:0] != `TSER_REG_CTRL
             && paddr[11:0] != `TSER_REG_STATUS && paddr[11:0] != `TSER_REG_CONFIG)
            pslverr <= 1'b0;
      end
   end
endmodule // tser_error_reporter

// >>> verif/tser_error_reporter_properties.sv
// Port-level checks for the error reporter
`timescale 1ns/1ps
module tser_checker (
   input wire       pclk,
   input wire       presetn,
   input wire       psel,
   input wire       penable,
   input wire       pready,
   input wire       pslverr,
   input wire       sink_valid,
   input wire [1:0] source_error,
   input wire       sink_ready,
   input wire       block_accept,
   input wire       core_reset_n
);
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_code_single: assert property (source_error != 2'h0 |=> source_error == 2'h0)
      else $error("error code held over one cycle");
   a_err_cause: assert property (source_error != 2'h0 |-> $past(sink_valid, 6))
      else $error("error code without input beat six cycles before");
   a_reset_stays: assert property ($fell(core_reset_n) |=> !core_reset_n [*8])
      else $error("forced reset released");
   a_ready_drops: assert property (!core_reset_n |-> !sink_ready)
      else $error("ready while held in reset");
   a_accept_quiet: assert property (!core_reset_n |-> !block_accept && source_error == 2'h0)
      else $error("activity while held in reset");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("ready held two cycles");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   a_slverr_pair: assert property (pslverr |-> pready)
      else $error("slave error without ready");
   c_no_start: cover property (source_error == 2'h1);
   c_other: cover property (source_error == 2'h3);
   c_expire: cover property ($fell(core_reset_n));
endmodule // tser_checker

// >>> verif/tser_src_model.sv
// Upstream stream source model
`timescale 1ns/1ps
module tser_src_model (
   input  wire        pclk,
   output reg         sink_valid,
   output reg         sink_sop,
   output reg         sink_eop,
   output reg  [1:0]  sink_error,
   output reg  [12:0] sink_blk_size,
   output reg         checksum_type_select
);
   initial begin
      {sink_valid, sink_sop, sink_eop, sink_error, sink_blk_size} = 18'h0;
      checksum_type_select = 1'b0;
   end
   // One beat per call, entered and left at a rising edge
   task automatic send(input logic v, s, e, input logic [1:0] err, input logic [12:0] k);
      sink_valid <= v;
      sink_sop <= s;
      sink_eop <= e;
      sink_error <= err;
      sink_blk_size <= s ? k : ~k;
      @(posedge pclk);
   endtask
endmodule // tser_src_model

// >>> verif/test_tser_error_reporter.sv
// Testbench for the error reporter
`timescale 1ns/1ps
module test_tser_error_reporter;
   localparam EV = 600;
   logic        pclk, presetn, psel, penable, pwrite, other_expire, rerr;
   logic [31:0] paddr, pwdata, rd;
   logic [1:0]  last_code;
   wire  [31:0] prdata;
   wire         pready, pslverr, sink_ready, block_accept, core_reset_n;
   wire         sink_valid, sink_sop, sink_eop, checksum_type_select;
   wire  [1:0]  sink_error, source_error;
   wire  [12:0] sink_blk_size;
   int          miscompares, num_checks, n_codes, n0, n_acc;
   tser_src_model u_src (.pclk(pclk), .sink_valid(sink_valid), .sink_sop(sink_sop),
      .sink_eop(sink_eop), .sink_error(sink_error), .sink_blk_size(sink_blk_size),
      .checksum_type_select(checksum_type_select));
   tser_error_reporter #(.EVAL_CYCLES(40'd600)) u_dut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sink_valid(sink_valid),
      .sink_sop(sink_sop), .sink_eop(sink_eop), .sink_error(sink_error),
      .sink_blk_size(sink_blk_size), .checksum_type_select(checksum_type_select),
      .other_expire(other_expire), .source_error(source_error), .sink_ready(sink_ready),
      .block_accept(block_accept), .core_reset_n(core_reset_n));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (source_error !== 2'h0) begin
         last_code <= source_error;
         n_codes <= n_codes + 1;
      end
      if (block_accept === 1'b1) n_acc <= n_acc + 1;
   end
   task chk(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [31:0] a, d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task codes(input int n, input logic [1:0] c);
      repeat (12) @(posedge pclk);
      chk(n_codes - n0, n);
      if (n > 0) chk(last_code, c);
      n0 = n_codes;
   endtask
   task wait_low;
      repeat (EV + 100) if (core_reset_n === 1'b1) @(posedge pclk);
   endtask
   task end_of_test;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge pclk);
      miscompares++;
      end_of_test;
   end
   initial begin
      {presetn, psel, penable, pwrite, other_expire, paddr, pwdata} = 69'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 32'h0, 32'h0);
      chk(rd, 32'h2);
      apb(1'b0, 32'hc, 32'h0);
      chk(rerr, 32'h1);
      apb(1'b0, 32'h8, 32'h0);
      chk(rd, 32'ha222);
      apb(1'b1, 32'h0, 32'h3);
      u_src.send(1, 0, 0, 2'h0, 40);
      u_src.send(0, 0, 0, 2'h0, 40);
      codes(1, 2'h1);
      u_src.send(1, 1, 0, 2'h0, 40);
      u_src.send(1, 0, 0, 2'h0, 40);
      u_src.send(1, 0, 1, 2'h0, 40);
      u_src.send(0, 0, 0, 2'h0, 40);
      codes(0, 2'h0);
      chk(n_acc, 32'h1);
      u_src.send(1, 1, 0, 2'h0, 40);
      u_src.send(1, 0, 0, 2'h2, 40);
      u_src.send(1, 0, 0, 2'h1, 40);
      u_src.send(1, 0, 1, 2'h0, 40);
      u_src.send(1, 0, 0, 2'h0, 40);
      u_src.send(0, 0, 0, 2'h0, 40);
      codes(1, 2'h2);
      u_src.send(1, 1, 0, 2'h0, 41);
      u_src.send(1, 0, 0, 2'h0, 41);
      u_src.send(1, 0, 1, 2'h0, 41);
      u_src.send(0, 0, 0, 2'h0, 41);
      codes(1, 2'h3);
      u_src.send(1, 1, 0, 2'h0, 40);
      u_src.send(1, 1, 0, 2'h0, 40);
      u_src.send(0, 0, 0, 2'h0, 40);
      codes(1, 2'h2);
      repeat (EV) @(posedge pclk);
      chk(core_reset_n, 32'h1);
      apb(1'b1, 32'h0, 32'h2);
      wait_low;
      repeat (20) @(posedge pclk);
      chk(core_reset_n, 32'h0);
      chk(sink_ready, 32'h0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b1, 32'h0, 32'h7);
      other_expire <= 1'b1;
      wait_low;
      chk(core_reset_n, 32'h0);
      end_of_test;
   end
endmodule // test_tser_error_reporter
bind tser_error_reporter tser_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .sink_valid(sink_valid),
   .source_error(source_error), .sink_ready(sink_ready), .block_accept(block_accept),
   .core_reset_n(core_reset_n));
